/* File: rtl/carrier_edge_shaper_212k.sv */
/*
 * Carrier amplitude edge shaper for the 212 kbit/s rate, with its three
 * configuration bytes and the 424 kbit/s modulation floor byte.
 * Assumes carrier_tick, mod_req and pa_supply_voltage come from logic on clk.
 */
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module carrier_edge_shaper_212k
    import edge_shaper_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       carrier_tick,
    input  wire logic       mod_req,
    input  wire logic [7:0] floor_212k,
    input  wire logic [7:0] pa_supply_voltage,
    output logic      [7:0] amp_out,
    output logic      [7:0] floor_amp_424k,
    output logic            edge_busy,
    output logic            cfg_reserved
);

    function automatic logic is_fw(input logic [3:0] c);
        return (c == CODE_FW1) || (c == CODE_FW2) || (c == CODE_FW3);
    endfunction

    function automatic logic is_tbl(input logic [3:0] c);
        return (c == CODE_TBL) || (c == CODE_TBL_CORR) || (c == CODE_TBL_ADPT);
    endfunction

    function automatic logic [7:0] lerp(input logic [7:0] y0, input logic [7:0] y1,
                                        input logic [7:0] dx, input int sh);
        logic [15:0] p;
        p = (16'(dx) * 16'(y1 - y0)) >> sh;
        return 8'(16'(y0) + p);
    endfunction

    function automatic logic [1:0] table_idx(input logic [2:0] sel);
        return (sel > 3'(TABLE_LAST)) ? TABLE_LAST : sel[1:0];
    endfunction

    logic [7:0] kind_r;
    logic [7:0] shape_r;
    logic [7:0] dur_r;
    logic [7:0] floor_r;
    logic [7:0] rdata_r;
    logic [7:0] amp_r;
    logic [7:0] amp_nxt;
    state_e     state_r;
    state_e     state_nxt;
    logic [4:0] step_r;
    logic [4:0] step_nxt;
    logic       hold_r;
    logic       hold_nxt;

    // Register port decode
    wire        wr_kind  = wr && (addr == OFS_KIND);
    wire        wr_shape = wr && (addr == OFS_SHAPE);
    wire        wr_dur   = wr && (addr == OFS_DUR);
    wire        wr_floor = wr && (addr == OFS_FLOOR);
    wire [7:0]  status   = {state_r, cfg_reserved, step_r};
    wire [7:0]  rd_mux   = (addr == OFS_KIND)   ? kind_r  :
                           (addr == OFS_SHAPE)  ? shape_r :
                           (addr == OFS_DUR)    ? dur_r   :
                           (addr == OFS_FLOOR)  ? floor_r :
                           (addr == OFS_STATUS) ? status  : 8'h00;

    // Per-edge configuration
    wire        falling   = (state_r == ST_FALL) || (state_r == ST_HIGH);
    wire [3:0]  fall_code = kind_r[FALL_KIND_LSB +: 4];
    wire [3:0]  rise_code = kind_r[RISE_KIND_LSB +: 4];
    wire [3:0]  cur_code  = falling ? fall_code : rise_code;
    wire [2:0]  cur_sel   = falling ? shape_r[FALL_SEL_LSB +: 3] : shape_r[RISE_SEL_LSB +: 3];
    wire        code_ok   = is_fw(cur_code) || is_tbl(cur_code);
    wire [4:0]  n_states  = dur_r[DUR_CNT_LSB +: 5];
    wire [1:0]  hold_cyc  = dur_r[DUR_DBL_BIT] ? CYC_STATE_DOUBLE : CYC_STATE_SINGLE;
    wire        shaped_ok = code_ok && (n_states != 5'h00);

    // Progress through the edge, 0..255
    wire [12:0] prod      = 13'(step_r) * 13'd255;
    wire [7:0]  frac      = (n_states == 5'h00) ? FULL_AMP : 8'(prod / 13'(n_states));

    // Firmware piecewise-linear shapes; knee height follows the time constant
    wire [7:0]  knee      = KNEE_BASE + {1'b0, cur_sel, 4'h0};
    wire [7:0]  knee_lo   = {1'b0, knee[7:1]};
    wire [7:0]  fw2_val   = (frac < 8'h80) ? lerp(8'h00, knee, frac, 7)
                                           : lerp(knee, FULL_AMP, frac - 8'h80, 7);
    wire [7:0]  fw3_val   = (frac < 8'h40) ? lerp(8'h00, knee_lo, frac, 6) :
                            (frac < 8'hC0) ? lerp(knee_lo, knee, frac - 8'h40, 7)
                                           : lerp(knee, FULL_AMP, frac - 8'hC0, 6);
    wire [7:0]  fw_val    = (cur_code == CODE_FW2) ? fw2_val :
                            (cur_code == CODE_FW3) ? fw3_val : frac;

    wire [1:0]  tbl_sel   = table_idx(cur_sel);
    wire [7:0]  tbl_val   = SHAPE_LUT[{tbl_sel, frac[7:5]}];
    // Supply adaptation scales the table by nominal over measured supply;
    // a zero reading is treated as one to keep the divider defined
    wire [7:0]  pa_safe   = (pa_supply_voltage == 8'h00) ? 8'h01 : pa_supply_voltage;
    wire [15:0] adapt_w   = (16'(tbl_val) * 16'(PA_NOMINAL)) / 16'(pa_safe);
    wire [7:0]  adapt_val = (adapt_w > 16'(FULL_AMP)) ? FULL_AMP : adapt_w[7:0];
    wire [8:0]  corr_w    = 9'(adapt_val) + 9'(CORR_STEP);
    wire [7:0]  corr_val  = corr_w[8] ? FULL_AMP : corr_w[7:0];
    wire [7:0]  tbl_out   = (cur_code == CODE_TBL_CORR) ? corr_val :
                            (cur_code == CODE_TBL_ADPT) ? adapt_val : tbl_val;
    wire [7:0]  shape_val = is_tbl(cur_code) ? tbl_out : fw_val;

    // Map shaped progress onto the span between full carrier and floor
    wire [7:0]  span      = FULL_AMP - floor_212k;
    wire [15:0] delta_w   = (16'(span) * 16'(shape_val)) >> 8;
    wire [7:0]  delta     = delta_w[7:0];
    wire        last_step = (step_r >= n_states);
    wire        advance   = carrier_tick && ((hold_cyc == CYC_STATE_SINGLE) || hold_r);

    always_comb begin
        state_nxt = state_r;
        step_nxt  = step_r;
        hold_nxt  = hold_r;
        amp_nxt   = amp_r;
        case (state_r)
            ST_HIGH: begin
                amp_nxt = FULL_AMP;
                if (mod_req) begin
                    if (shaped_ok) begin
                        state_nxt = ST_FALL;
                        step_nxt  = 5'h01;
                        hold_nxt  = 1'b0;
                    end else begin
                        state_nxt = ST_LOW;
                        amp_nxt   = floor_212k;
                    end
                end
            end
            ST_FALL: begin
                amp_nxt = FULL_AMP - delta;
                if (carrier_tick && !advance) begin
                    hold_nxt = 1'b1;
                end else if (advance) begin
                    hold_nxt = 1'b0;
                    if (last_step) begin
                        state_nxt = ST_LOW;
                        step_nxt  = 5'h00;
                        amp_nxt   = floor_212k;
                    end else begin
                        step_nxt = step_r + 5'h01;
                    end
                end
            end
            ST_LOW: begin
                amp_nxt = floor_212k;
                if (!mod_req) begin
                    if (shaped_ok) begin
                        state_nxt = ST_RISE;
                        step_nxt  = 5'h01;
                        hold_nxt  = 1'b0;
                    end else begin
                        state_nxt = ST_HIGH;
                        amp_nxt   = FULL_AMP;
                    end
                end
            end
            ST_RISE: begin
                amp_nxt = floor_212k + delta;
                if (carrier_tick && !advance) begin
                    hold_nxt = 1'b1;
                end else if (advance) begin
                    hold_nxt = 1'b0;
                    if (last_step) begin
                        state_nxt = ST_HIGH;
                        step_nxt  = 5'h00;
                        amp_nxt   = FULL_AMP;
                    end else begin
                        step_nxt = step_r + 5'h01;
                    end
                end
            end
            default: begin
                state_nxt = ST_HIGH;
                step_nxt  = 5'h00;
                hold_nxt  = 1'b0;
                amp_nxt   = FULL_AMP;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            kind_r  <= RST_KIND;
            shape_r <= RST_SHAPE;
            dur_r   <= RST_DUR;
            floor_r <= RST_FLOOR;
            rdata_r <= 8'h00;
        end else begin
            if (wr_kind)  kind_r  <= wdata;
            if (wr_shape) shape_r <= wdata;
            if (wr_dur)   dur_r   <= wdata;
            if (wr_floor) floor_r <= wdata;
            rdata_r <= rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_HIGH;
            step_r  <= 5'h00;
            hold_r  <= 1'b0;
            amp_r   <= FULL_AMP;
        end else begin
            state_r <= state_nxt;
            step_r  <= step_nxt;
            hold_r  <= hold_nxt;
            amp_r   <= amp_nxt;
        end
    end

    assign rdata          = rdata_r;
    assign amp_out        = amp_r;
    assign floor_amp_424k = floor_r;
    assign edge_busy      = (state_r == ST_FALL) || (state_r == ST_RISE);
    // Reserved codes collapse edges to a step instead of guessing a shape
    assign cfg_reserved   = !(is_fw(fall_code) || is_tbl(fall_code))
                         || !(is_fw(rise_code) || is_tbl(rise_code));

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    fall_nibble_a: assert property (
        (state_r == ST_FALL) |-> (cur_code == kind_r[7:4]))
        else $error("falling edge not using upper kind nibble");
    fixed_table_a: assert property (
        (edge_busy && cur_code == CODE_TBL) |-> (shape_val == SHAPE_LUT[{tbl_sel, frac[7:5]}]))
        else $error("code 4 table value altered");
    adapt_corr_a: assert property (
        (edge_busy && cur_code == CODE_TBL_CORR && adapt_val < 8'hF0)
            |-> (shape_val == adapt_val + CORR_STEP))
        else $error("code 5 correction missing");
    adapt_only_a: assert property (
        (edge_busy && cur_code == CODE_TBL_ADPT && pa_supply_voltage == PA_NOMINAL)
            |-> (shape_val == tbl_val))
        else $error("code 6 output differs at nominal supply");
    rise_nibble_a: assert property (
        (state_r == ST_RISE) |-> (cur_code == kind_r[3:0]))
        else $error("rising edge not using lower kind nibble");
    sel_field_a: assert property (
        (state_r == ST_FALL) |-> (cur_sel == shape_r[6:4]))
        else $error("falling edge field wrong");
    rise_field_a: assert property (
        (state_r == ST_RISE) |-> (cur_sel == shape_r[2:0]))
        else $error("rising edge field wrong");
    table_limit_a: assert property (
        (edge_busy && shape_r[6:4] > 3'h3 && state_r == ST_FALL) |-> (tbl_sel == 2'h3))
        else $error("table index not limited");
    single_hold_a: assert property (
        (state_r == ST_FALL && carrier_tick && !dur_r[7] && !last_step)
            |=> (step_r == $past(step_r) + 5'h01))
        else $error("single-cycle state did not advance");
    double_hold_a: assert property (
        (edge_busy && carrier_tick && dur_r[7] && !hold_r)
            |=> (step_r == $past(step_r)) && hold_r)
        else $error("double-cycle state advanced early");
    state_count_a: assert property (
        (state_r == ST_FALL && advance && last_step) |=> (state_r == ST_LOW) && (amp_out == $past(floor_212k)))
        else $error("edge did not end after programmed states");
    floor_write_a: assert property (
        wr_floor |=> (floor_amp_424k == $past(wdata)))
        else $error("floor byte not applied");
    floor_linear_a: assert property (
        (floor_r == 8'hFF) |-> (floor_amp_424k == FULL_AMP))
        else $error("full floor code not full amplitude");
    // Rising selections above 3 must use the last shape table
    rise_limit_a: assert property (
        (state_r == ST_RISE && shape_r[2:0] > 3'h3) |-> (tbl_sel == 2'h3))
        else $error("rising table index not limited");
    rise_single_a: assert property (
        (state_r == ST_RISE && carrier_tick && !dur_r[7] && !last_step)
            |=> (step_r == $past(step_r) + 5'h01))
        else $error("single-cycle rising state did not advance");
    dbl_advance_a: assert property (
        (edge_busy && carrier_tick && dur_r[7] && hold_r && !last_step)
            |=> (step_r == $past(step_r) + 5'h01) && !hold_r)
        else $error("double-cycle state did not advance on second tick");
    rise_count_a: assert property (
        (state_r == ST_RISE && advance && last_step) |=> (state_r == ST_HIGH) && (amp_out == FULL_AMP))
        else $error("rising edge did not end after programmed states");
    edge_start_a: assert property (
        (state_r == ST_HIGH && mod_req && shaped_ok) |=> (state_r == ST_FALL) && (step_r == 5'h01))
        else $error("falling edge did not start at first state");
    step_edge_a: assert property (
        (state_r == ST_HIGH && mod_req && !shaped_ok)
            |=> (state_r == ST_LOW) && (amp_out == $past(floor_212k)))
        else $error("unshaped falling edge not a plain step");
    busy_step_a: assert property (
        edge_busy |-> (step_r != 5'h00) && (step_r <= n_states))
        else $error("edge state index out of range");
    kind_read_a: assert property (
        (rd && addr == OFS_KIND) |=> (rdata == $past(kind_r)))
        else $error("kind byte read back wrong");
    floor_read_a: assert property (
        (rd && addr == OFS_FLOOR) |=> (rdata == $past(floor_r)))
        else $error("floor byte read back wrong");
    floor_zero_a: assert property (
        (floor_r == 8'h00) |-> (floor_amp_424k == 8'h00))
        else $error("zero floor code not zero amplitude");

    fall_done_c: cover property ((state_r == ST_FALL) ##1 (state_r == ST_LOW));
    rise_done_c: cover property ((state_r == ST_RISE) ##1 (state_r == ST_HIGH));
    dbl_hold_c:  cover property (edge_busy && hold_r && carrier_tick);
    adapt_c:     cover property (edge_busy && cur_code == CODE_TBL_CORR);
    tbl_clamp_c: cover property (edge_busy && is_tbl(cur_code) && (cur_sel > 3'h3));

endmodule // carrier_edge_shaper_212k
`default_nettype wire

/* File: shared/edge_shaper_pkg.sv */
/*
 * Constants, register map, edge codes, shape table and state type for the
 * 212 kbit/s carrier edge shaper.
 * Assumes a single 125 MHz clock and an 8-bit register port.
 */
`default_nettype none
package edge_shaper_pkg;
    // Register offsets on the 8-bit register port
    localparam logic [7:0] OFS_KIND   = 8'h29;
    localparam logic [7:0] OFS_SHAPE  = 8'h2A;
    localparam logic [7:0] OFS_DUR    = 8'h2B;
    localparam logic [7:0] OFS_FLOOR  = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h3F;
    // Values after reset
    localparam logic [7:0] RST_KIND  = 8'h11;
    localparam logic [7:0] RST_SHAPE = 8'h00;
    localparam logic [7:0] RST_DUR   = 8'h04;
    localparam logic [7:0] RST_FLOOR = 8'h00;
    // Field positions
    localparam int FALL_KIND_LSB = 4;
    localparam int RISE_KIND_LSB = 0;
    localparam int FALL_SEL_LSB  = 4;
    localparam int RISE_SEL_LSB  = 0;
    localparam int DUR_DBL_BIT   = 7;
    localparam int DUR_CNT_LSB   = 0;
    // Edge kind codes
    localparam logic [3:0] CODE_FW1      = 4'h1;
    localparam logic [3:0] CODE_FW2      = 4'h2;
    localparam logic [3:0] CODE_FW3      = 4'h3;
    localparam logic [3:0] CODE_TBL      = 4'h4;
    localparam logic [3:0] CODE_TBL_CORR = 4'h5;
    localparam logic [3:0] CODE_TBL_ADPT = 4'h6;
    // Amplitude and shaping constants
    localparam logic [7:0] FULL_AMP   = 8'hFF;
    localparam logic [7:0] PA_NOMINAL = 8'h80;
    localparam logic [7:0] CORR_STEP  = 8'h04;
    localparam logic [7:0] KNEE_BASE  = 8'h40;
    localparam logic [1:0] TABLE_LAST = 2'h3;
    // Carrier cycles per transition state
    localparam logic [1:0] CYC_STATE_SINGLE = 2'h1;
    localparam logic [1:0] CYC_STATE_DOUBLE = 2'h2;
    // Four shape tables of eight points each
    localparam logic [7:0] SHAPE_LUT [0:31] = '{
        8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hB0, 8'hD0, 8'hFF,
        8'h04, 8'h10, 8'h28, 8'h48, 8'h70, 8'hA0, 8'hD0, 8'hFF,
        8'h40, 8'h70, 8'h98, 8'hB8, 8'hD0, 8'hE4, 8'hF4, 8'hFF,
        8'h08, 8'h18, 8'h38, 8'h70, 8'hB0, 8'hD8, 8'hF0, 8'hFF};
    typedef enum logic [1:0] {
        ST_HIGH = 2'b00,
        ST_FALL = 2'b01,
        ST_LOW  = 2'b10,
        ST_RISE = 2'b11
    } state_e;
endpackage
`default_nettype wire

/* File: verif/amp_stage_model.sv */
/*
 * Model of the transmitter amplitude stage: paces carrier cycles and
 * takes the shaped amplitude as the field level.
 * Assumes the shaper's clk and resetn; slow stretches the carrier period.
 */
`timescale 1ns/1ns
`default_nettype none
module amp_stage_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       slow,
    input  wire logic [7:0] amp_out,
    output logic            carrier_tick,
    output logic      [7:0] field_level
);
    logic [3:0] cnt_r;
    // carrier cycle pacing
    // Period of 5 or 9 clocks, so a step never ends in the cycle it starts
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r        <= 4'h0;
            carrier_tick <= 1'b0;
        end else if (cnt_r == (slow ? 4'h8 : 4'h4)) begin
            cnt_r        <= 4'h0;
            carrier_tick <= 1'b1;
        end else begin
            cnt_r        <= cnt_r + 4'h1;
            carrier_tick <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        field_level <= amp_out;
    end
endmodule // amp_stage_model
`default_nettype wire

/* File: verif/carrier_edge_shaper_212k_test.sv */
/*
 * Self-checking bench for the 212k carrier edge shaper.
 * Assumes the shaper package and the amplitude stage model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module carrier_edge_shaper_212k_test;
    import edge_shaper_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        mod_req = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  floor_212k = 8'h00;
    logic [7:0]  pa = PA_NOMINAL;
    logic [7:0]  rdata, amp_out, floor_amp_424k, field_level, v;
    logic        carrier_tick, edge_busy, cfg_reserved;
    logic [31:0] lfsr = 32'hB496C9AF;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cycles = 0;
    // reserved bits zero; the 0x71 case programs a reserved code on purpose
    logic [7:0]  kd [7] = '{8'h41, 8'h56, 8'h65, 8'h23, 8'h14, 8'h32, 8'h71};
    logic [7:0]  sh [7] = '{8'h20, 8'h71, 8'h12, 8'h77, 8'h05, 8'h40, 8'h00};
    logic [7:0]  du [7] = '{8'h04, 8'h83, 8'h01, 8'h1F, 8'h02, 8'h00, 8'h04};
    logic [7:0]  ofs [5] = '{OFS_KIND, OFS_SHAPE, OFS_DUR, OFS_FLOOR, OFS_STATUS};
    logic [7:0]  rst [5] = '{RST_KIND, RST_SHAPE, RST_DUR, RST_FLOOR, 8'h00};

    always #4 clk = ~clk;

    carrier_edge_shaper_212k DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .carrier_tick(carrier_tick), .mod_req(mod_req),
        .floor_212k(floor_212k), .pa_supply_voltage(pa), .amp_out(amp_out),
        .floor_amp_424k(floor_amp_424k), .edge_busy(edge_busy), .cfg_reserved(cfg_reserved));
    amp_stage_model partner (.clk(clk), .resetn(resetn), .slow(slow), .amp_out(amp_out),
        .carrier_tick(carrier_tick), .field_level(field_level));

    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    function automatic logic reserved(logic [3:0] c);
        return (c < CODE_FW1) || (c > CODE_TBL_ADPT);
    endfunction

    // Amplitude of the first step; only the linear and table styles have a fixed figure
    function automatic logic [7:0] exp_amp(logic fall, logic [3:0] code, logic [2:0] sel, int cnt,
                                           logic [7:0] fl, logic [7:0] p);
        int frac, s, idx, d;
        frac = 255 / cnt;
        idx = (sel > 3) ? 3 : sel;
        s = (code == CODE_FW1) ? frac : SHAPE_LUT[idx * 8 + frac / 32];
        if (code != CODE_FW1 && code != CODE_TBL) s = s * PA_NOMINAL / ((p == 8'h00) ? 1 : p);
        if (s > 255) s = 255;
        if (code == CODE_TBL_CORR) s = s + CORR_STEP;
        if (s > 255) s = 255;
        d = ((255 - fl) * s) >> 8;
        return fall ? 8'(255 - d) : 8'(fl + d);
    endfunction

    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", exp, rdata);
    endtask

    task automatic run_edge(logic fall, logic [3:0] code, logic [2:0] sel, logic [7:0] dur);
        int ticks, cnt, w;
        logic shaped;
        cnt = dur[4:0];
        shaped = (cnt != 0) && !reserved(code);
        ticks = 0;
        w = 0;
        @(posedge clk);
        while (carrier_tick !== 1'b1) @(posedge clk);
        mod_req <= fall;
        repeat (2) @(posedge clk);
        #1;
        check("edge_busy", {7'h00, shaped}, {7'h00, edge_busy});
        if (shaped && code != CODE_FW2 && code != CODE_FW3)
            check("amp_out", exp_amp(fall, code, sel, cnt, floor_212k, pa), amp_out);
        while (edge_busy === 1'b1 && w < 2000) begin
            @(posedge clk);
            w++;
            if (carrier_tick === 1'b1 && edge_busy === 1'b1) ticks++;
        end
        #1;
        check("ticks", shaped ? 8'(cnt * (dur[7] ? 2 : 1)) : 8'h00, 8'(ticks));
        check("amp_out", fall ? floor_212k : FULL_AMP, amp_out);
    endtask

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check("amp_out", FULL_AMP, amp_out);
        check("cfg_reserved", 8'h00, {7'h00, cfg_reserved});
        for (int i = 0; i < 5; i++) rd_chk(ofs[i], rst[i]);
        wr_reg(8'h10, 8'h5A);
        rd_chk(8'h10, 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? FULL_AMP : rnd();
            wr_reg(OFS_FLOOR, v);
            check("floor_amp_424k", v, floor_amp_424k);
            rd_chk(OFS_FLOOR, v);
        end
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            floor_212k <= rnd();
            // Nominal supply once, so code 6 must leave the table unchanged
            pa <= (i == 2) ? PA_NOMINAL : rnd();
            slow <= i[0];
            wr_reg(OFS_KIND, kd[i]);
            wr_reg(OFS_SHAPE, sh[i]);
            wr_reg(OFS_DUR, du[i]);
            rd_chk(OFS_KIND, kd[i]);
            check("cfg_reserved", {7'h00, reserved(kd[i][7:4]) | reserved(kd[i][3:0])},
                  {7'h00, cfg_reserved});
            run_edge(1'b1, kd[i][7:4], sh[i][6:4], du[i]);
            rd_chk(OFS_STATUS, {ST_LOW, reserved(kd[i][7:4]) | reserved(kd[i][3:0]), 5'h00});
            run_edge(1'b0, kd[i][3:0], sh[i][2:0], du[i]);
        end
        @(posedge clk);
        #1;
        check("field_level", FULL_AMP, field_level);
        stop_test();
    end
endmodule // carrier_edge_shaper_212k_test
`default_nettype wire
